// ### rtl/rx_alarm_regs.svh
/*
  Constants for the receive alarm and drop bus clock block: loss
  criteria, drop bus clock rates and the system clock rate.
  Assumes inclusion by bare name from the rtl/ files.
*/
`ifndef RX_ALARM_REGS_SVH
`define RX_ALARM_REGS_SVH

// ----------------------------------------------------------------
// loss declare and clear criteria, in received bits or, for the e3 good count, blocks
// ----------------------------------------------------------------
`define RXA_DS3_LOS_ZEROS   16'h00B4
`define RXA_E3_LOS_ZEROS    16'h0020
`define RXA_DS3_WINDOW      8'hB4
`define RXA_DS3_MIN_ONES    8'h3C
`define RXA_E3_BLOCK        8'h20
`define RXA_E3_MIN_ONES     8'h08
`define RXA_E3_GOOD_BLOCKS  3'h4

// ----------------------------------------------------------------
// clock rates in Hz
// ----------------------------------------------------------------
`define RXA_CLK_HZ          200000000
`define RXA_DROP_STS3_HZ    19440000
`define RXA_DROP_STS1_HZ    6480000

// ----------------------------------------------------------------
// scan word layout
// ----------------------------------------------------------------
`define RXA_SCAN_LOSS_BIT   0

`endif

// ### rtl/rx_alarm_pkg.sv
/*
  Types shared by the receive alarm block: line mode, drop bus
  source word and the state records of both modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package rx_alarm_pkg;

  typedef enum logic [1:0] {MODE_DS3, MODE_E3, MODE_STS1} line_mode_e;

  typedef struct packed {
    logic [7:0] data;
    logic       payload;
    logic       alarm;
    logic       marker;
  } drop_src_s;

  typedef struct packed {
    logic [15:0] zero_run;
    logic [7:0]  win;
    logic [7:0]  ones;
    logic [2:0]  good;
    logic        loss;
  } loss_state_s;

  typedef struct packed {
    logic        ext_s1;
    logic        ext_s2;
    logic        lclk_s1;
    logic        lclk_s2;
    logic        lclk_s3;
    logic        pos_s1;
    logic        pos_s2;
    logic        neg_s1;
    logic        neg_s2;
    logic [31:0] acc;
    logic [7:0]  scan;
    logic        frame_lost;
    logic        signal_lost;
    logic        drop_clk;
    logic [7:0]  data;
    logic        parity;
    logic        payload;
    logic        alarm;
    logic        marker;
  } chan_state_s;

endpackage

`default_nettype wire

// ### rtl/line_loss_monitor.sv
/*
  Zero-run loss declaration and ones-density loss clearing on the
  received bit stream of one channel.
  Assumes bits arrive as one-cycle strobes on i_clock.
*/
`default_nettype none
`include "rx_alarm_regs.svh"

module line_loss_monitor
  import rx_alarm_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_bit_valid,
  input  wire logic        i_bit_value,
  input  wire line_mode_e  i_mode,
  input  wire logic [15:0] i_rx_loss_threshold,
  output logic             o_loss
);

  loss_state_s st;
  loss_state_s next_st;
  logic [15:0] thr;
  logic [7:0]  blk_len;
  logic [7:0]  min_ones;
  logic [7:0]  ones_inc;
  logic [15:0] run_inc;
  logic [2:0]  good_inc;
  logic        blk_ok;
  logic        blk_end;
  logic        aligned;

  // ----------------------------------------------------------------
  // declare and clear
  // ----------------------------------------------------------------
  always_comb begin
    next_st  = st;
    thr      = (i_mode == MODE_DS3) ? `RXA_DS3_LOS_ZEROS :
               (i_mode == MODE_E3)  ? `RXA_E3_LOS_ZEROS : i_rx_loss_threshold;
    blk_len  = (i_mode == MODE_E3) ? `RXA_E3_BLOCK : `RXA_DS3_WINDOW;
    min_ones = (i_mode == MODE_E3) ? `RXA_E3_MIN_ONES : `RXA_DS3_MIN_ONES;
    ones_inc = st.ones + 8'(i_bit_value);
    run_inc  = (st.zero_run == 16'hFFFF) ? st.zero_run : st.zero_run + 16'h0001;
    good_inc = (st.good == 3'h7) ? st.good : st.good + 3'h1;
    blk_ok   = ones_inc >= min_ones;
    blk_end  = st.win >= blk_len - 8'h01;
    aligned  = st.win == blk_len - 8'h01;
    if (i_bit_valid) begin
      // a block stretched by a mode change closes at once and never counts
      if (blk_end) begin
        next_st.win  = 8'h00;
        next_st.ones = 8'h00;
        next_st.good = (blk_ok && aligned && i_mode == MODE_E3) ? good_inc : 3'h0;
        if (st.loss && blk_ok && aligned &&
            (i_mode != MODE_E3 || good_inc >= `RXA_E3_GOOD_BLOCKS)) begin
          next_st.loss = 1'b0;
          next_st.good = 3'h0;
        end
      end else begin
        next_st.win  = st.win + 8'h01;
        next_st.ones = ones_inc;
      end
      next_st.zero_run = i_bit_value ? 16'h0000 : run_inc;
      if (!i_bit_value && run_inc >= thr && thr != 16'h0000) begin
        next_st.loss = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_loss = st.loss;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  declare_zero_run_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $rose(st.loss) |-> $past(i_bit_valid) && !$past(i_bit_value)
      && $past(st.zero_run) + 16'h0001 >= $past(thr))
    else $error("loss declared without enough zeros");

  ds3_clear_window_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $fell(st.loss) && $past(i_mode) == MODE_DS3 |->
      $past(st.win) == 8'hB3 && $past(ones_inc) >= 8'h3C)
    else $error("ds3 loss cleared without 60 ones in 180 bits");

  e3_clear_blocks_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $fell(st.loss) && $past(i_mode) == MODE_E3 |->
      $past(st.good) >= 3'h3 && $past(ones_inc) >= 8'h08 && $past(st.win) == 8'h1F)
    else $error("e3 loss cleared without four good blocks");

endmodule

`default_nettype wire

// ### rtl/rx_channel_alarm.sv
/*
  One receive channel: loss and out-of-frame indicators, line loss
  scan bit, and the drop telecom bus clock with its launched outputs
  or the alternate pin functions while the bus is disabled.
  Assumes the framer, hdlc and atm logic run on i_clock; the line
  interface pins and the line clock are asynchronous.
*/
`default_nettype none
`include "rx_alarm_regs.svh"

// Behaviour
// - external loss high declares loss of signal
// - external loss level readable as scan bit 0
// - frame lost output follows framer out-of-frame
// - declare loss after 180/32 consecutive zeros
// - ds3 clears on 60 ones in 180
// - e3 clears on four good 32-bit blocks
// - drop bus outputs launch on clock rise
// - drop clock 19.44 or 6.48 MHz
// - disabled bus pin carries hdlc or atm
module rx_channel_alarm
  import rx_alarm_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_ext_line_loss_in,
  input  wire logic        i_rx_line_clk,
  input  wire logic        i_rx_line_pos_in,
  input  wire logic        i_rx_line_neg_in,
  input  wire line_mode_e  i_mode,
  input  wire logic [15:0] i_rx_loss_threshold,
  input  wire logic        i_framer_oof,
  input  wire logic        i_drop_enable,
  input  wire logic        i_drop_sts3,
  input  wire drop_src_s   i_drop_src,
  input  wire logic        i_drop_alt_atm,
  input  wire logic        i_hdlc_rx_check_ok,
  input  wire logic        i_atm_rx_flowctl_clk,
  output logic [7:0]       o_line_scan,
  output logic             o_liu_loss_flag,
  output logic             o_rx_frame_lost_out,
  output logic             o_rx_signal_lost_out,
  output logic             o_drop_bus_clk_out,
  output logic [7:0]       o_drop_bus_byte_out,
  output logic             o_drop_bus_parity_out,
  output logic             o_drop_bus_payload_flag,
  output logic             o_drop_bus_alarm_out,
  output logic             o_drop_bus_frame_marker
);

  // ----------------------------------------------------------------
  // drop clock phase steps
  // ----------------------------------------------------------------
  localparam logic [31:0] STEP_STS3 =
    32'((64'(`RXA_DROP_STS3_HZ) << 32) / 64'(`RXA_CLK_HZ));
  localparam logic [31:0] STEP_STS1 =
    32'((64'(`RXA_DROP_STS1_HZ) << 32) / 64'(`RXA_CLK_HZ));

  chan_state_s st;
  chan_state_s next_st;
  logic        bit_valid;
  logic        bit_value;
  logic        mon_loss;
  logic [31:0] acc_next;
  logic        rise;

  assign bit_valid = st.lclk_s2 & ~st.lclk_s3;
  assign bit_value = st.pos_s2 | st.neg_s2;

  // ----------------------------------------------------------------
  // zero run and ones density monitor
  // ----------------------------------------------------------------
  line_loss_monitor u_monitor (
    .i_clock             (i_clock),
    .i_resetn            (i_resetn),
    .i_bit_valid         (bit_valid),
    .i_bit_value         (bit_value),
    .i_mode              (i_mode),
    .i_rx_loss_threshold (i_rx_loss_threshold),
    .o_loss              (mon_loss)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st         = st;
    next_st.ext_s1  = i_ext_line_loss_in;
    next_st.ext_s2  = st.ext_s1;
    next_st.lclk_s1 = i_rx_line_clk;
    next_st.lclk_s2 = st.lclk_s1;
    next_st.lclk_s3 = st.lclk_s2;
    next_st.pos_s1  = i_rx_line_pos_in;
    next_st.pos_s2  = st.pos_s1;
    next_st.neg_s1  = i_rx_line_neg_in;
    next_st.neg_s2  = st.neg_s1;

    next_st.scan                   = 8'h00;
    next_st.scan[`RXA_SCAN_LOSS_BIT] = st.ext_s2;
    next_st.frame_lost  = i_framer_oof;
    next_st.signal_lost = mon_loss | st.ext_s2;

    acc_next = st.acc + (i_drop_sts3 ? STEP_STS3 : STEP_STS1);
    rise     = i_drop_enable && !st.acc[31] && acc_next[31];
    if (i_drop_enable) begin
      next_st.acc      = acc_next;
      next_st.drop_clk = acc_next[31];
    end else begin
      next_st.acc      = 32'h0000_0000;
      next_st.drop_clk = i_drop_alt_atm ? i_atm_rx_flowctl_clk : i_hdlc_rx_check_ok;
    end
    if (rise) begin
      next_st.data    = i_drop_src.data;
      next_st.parity  = ^i_drop_src.data;
      next_st.payload = i_drop_src.payload;
      next_st.alarm   = i_drop_src.alarm;
      next_st.marker  = i_drop_src.marker;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_line_scan             = st.scan;
  assign o_liu_loss_flag         = st.scan[`RXA_SCAN_LOSS_BIT];
  assign o_rx_frame_lost_out     = st.frame_lost;
  assign o_rx_signal_lost_out    = st.signal_lost;
  assign o_drop_bus_clk_out      = st.drop_clk;
  assign o_drop_bus_byte_out     = st.data;
  assign o_drop_bus_parity_out   = st.parity;
  assign o_drop_bus_payload_flag = st.payload;
  assign o_drop_bus_alarm_out    = st.alarm;
  assign o_drop_bus_frame_marker = st.marker;

  // ----------------------------------------------------------------
  // helper: cycles between drop clock rises in a steady mode
  // ----------------------------------------------------------------
  logic [7:0] gap;
  logic       gap_valid;
  logic       mode_prev;
  logic       en_prev;

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      gap       <= 8'h00;
      gap_valid <= 1'b0;
      mode_prev <= 1'b0;
      en_prev   <= 1'b0;
    end else begin
      mode_prev <= i_drop_sts3;
      en_prev   <= i_drop_enable;
      if (mode_prev != i_drop_sts3 || !i_drop_enable || !en_prev) begin
        gap_valid <= 1'b0;
        gap       <= 8'h00;
      end else if (rise) begin
        gap_valid <= 1'b1;
        gap       <= 8'h01;
      end else begin
        gap       <= (gap == 8'hFF) ? gap : gap + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  ext_loss_declare_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_ext_line_loss_in [*3] |=> o_rx_signal_lost_out)
    else $error("external loss did not raise signal lost");

  scan_bit_level_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $past(i_resetn, 4) |-> o_liu_loss_flag == $past(i_ext_line_loss_in, 3))
    else $error("scan bit does not track external loss input");

  frame_lost_follow_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_framer_oof != o_rx_frame_lost_out |=> o_rx_frame_lost_out == $past(i_framer_oof))
    else $error("frame lost output does not follow framer");

  drop_launch_edge_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $changed(o_drop_bus_byte_out) && $past(i_drop_enable) |-> $rose(o_drop_bus_clk_out))
    else $error("drop bus byte changed away from clock rise");

  drop_parity_match_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_drop_bus_parity_out == ^o_drop_bus_byte_out)
    else $error("drop bus parity does not match byte");

  drop_clock_rate_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    rise && gap_valid && mode_prev == i_drop_sts3 && en_prev |->
      (i_drop_sts3 ? (gap == 8'h0A || gap == 8'h0B) : (gap == 8'h1E || gap == 8'h1F)))
    else $error("drop clock period off rate");

  alt_pin_select_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    !i_drop_enable |=> o_drop_bus_clk_out ==
      ($past(i_drop_alt_atm) ? $past(i_atm_rx_flowctl_clk) : $past(i_hdlc_rx_check_ok)))
    else $error("disabled drop clock pin not carrying alternate function");

endmodule

`default_nettype wire

// ### tb/liu_model.sv
/*
  Line interface model: line clock, bipolar receive data and the
  external loss level of one channel.
  Assumes the bench calls its tasks; the clock idles low between frames.
*/
`default_nettype none

module liu_model (
  output var logic o_line_clk,
  output var logic o_pos,
  output var logic o_neg,
  output var logic o_ext_loss
);
  timeunit 1ns;
  timeprecision 100ps;

  logic mark;

  initial begin
    o_line_clk = 1'b0;
    o_pos      = 1'b0;
    o_neg      = 1'b0;
    o_ext_loss = 1'b0;
    mark       = 1'b0;
  end

  // ones alternate between the two rails; a 64 ns bit period
  task automatic send(input int n, input logic one);
    for (int i = 0; i < n; i++) begin
      o_pos = one & ~mark;
      o_neg = one & mark;
      mark  = mark ^ one;
      #32 o_line_clk = 1'b1;
      #32 o_line_clk = 1'b0;
    end
    // released rails show the inverse of the last value
    o_pos = ~o_pos;
    o_neg = ~o_neg;
  endtask

  task automatic loss(input logic lvl);
    o_ext_loss = lvl;
  endtask
endmodule

`default_nettype wire

// ### tb/rx_channel_alarm_and_drop_bus_clock_tb.sv
/*
  Self-checking bench of one receive alarm channel.
  Assumes the design package and the line interface model.
*/
`default_nettype none

module rx_channel_alarm_and_drop_bus_clock_tb
  import rx_alarm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       i_clock, i_resetn, lclk, pos, neg, ext, oof, den, sts3;
  logic       alt_atm, hdlc, atm, liu_f, fl, sl, dclk, par, pl, al, mk;
  logic       first, pclk;
  logic [7:0] scan, byte_o, lb;
  logic [15:0] thr;
  logic [11:0] exp_v;
  line_mode_e mode;
  drop_src_s  src, e;
  drop_src_s  exp_q[$];
  int         err_total, total_checks, seed, cyc, gap;

  liu_model liu_u (.o_line_clk(lclk), .o_pos(pos), .o_neg(neg), .o_ext_loss(ext));

  rx_channel_alarm dut_u (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_ext_line_loss_in(ext),
    .i_rx_line_clk(lclk), .i_rx_line_pos_in(pos), .i_rx_line_neg_in(neg),
    .i_mode(mode), .i_rx_loss_threshold(thr), .i_framer_oof(oof),
    .i_drop_enable(den), .i_drop_sts3(sts3), .i_drop_src(src),
    .i_drop_alt_atm(alt_atm), .i_hdlc_rx_check_ok(hdlc),
    .i_atm_rx_flowctl_clk(atm), .o_line_scan(scan), .o_liu_loss_flag(liu_f),
    .o_rx_frame_lost_out(fl), .o_rx_signal_lost_out(sl),
    .o_drop_bus_clk_out(dclk), .o_drop_bus_byte_out(byte_o),
    .o_drop_bus_parity_out(par), .o_drop_bus_payload_flag(pl),
    .o_drop_bus_alarm_out(al), .o_drop_bus_frame_marker(mk)
  );

  // ----------------------------------------------------------------
  // clock, timeout, compare and verdict
  // ----------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  // ----------------------------------------------------------------
  // drop bus watcher: takes the oldest note at each launch
  // ----------------------------------------------------------------
  always @(negedge i_clock) begin
    if (i_resetn) begin
      if (den && dclk && !pclk) begin
        if (!first) check(gap == (sts3 ? 10 : 30) || gap == (sts3 ? 11 : 31), 1);
        e     = exp_q.pop_front();
        exp_v = {e.data, ^e.data, e.payload, e.alarm, e.marker};
        check({byte_o, par, pl, al, mk}, exp_v);
        first = 1'b0;
        gap   = 0;
      end else check(byte_o, lb);
      gap++;
      pclk = dclk;
      lb   = byte_o;
    end
  end

  task automatic drop_run(input logic s3, input int k);
    first = 1'b1;
    sts3  = s3;
    src   = drop_src_s'($random(seed));
    exp_q.push_back(src);
    den   = 1'b1;
    for (int i = 0; i < k; i++) begin
      @(posedge dclk);
      @(negedge i_clock);
      if (i < k - 1) begin
        src = drop_src_s'($random(seed));
        exp_q.push_back(src);
      end
    end
    wait_n(2);
    den = 1'b0;
    wait_n(2);
  endtask

  task automatic loss_case(input line_mode_e m, input int n, input logic lost);
    mode = m;
    liu_u.send(400, 1'b1);
    wait_n(8);
    check(sl, 1'b0);
    liu_u.send(n - 1, 1'b0);
    wait_n(8);
    check(sl, 1'b0);
    liu_u.send(1, 1'b0);
    wait_n(8);
    check(sl, lost);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {oof, den, sts3, alt_atm, hdlc, atm, lb, pclk, first} = '0;
    {err_total, total_checks, cyc, gap} = '0;
    seed     = 22631;
    mode     = MODE_DS3;
    thr      = 16'h0000;
    src      = '0;
    i_resetn = 1'b0;
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    i_resetn = 1'b1;
    wait_n(1);
    check({scan, liu_f, fl, sl, dclk, byte_o}, 0);
    liu_u.loss(1'b1);
    wait_n(8);
    check({scan, liu_f, sl}, {8'h01, 1'b1, 1'b1});
    liu_u.loss(1'b0);
    wait_n(8);
    check({scan, liu_f, sl}, 0);
    repeat (20) begin
      oof = 1'($random(seed));
      @(negedge i_clock);
      check(fl, oof);
    end
    oof = 1'b0;
    drop_run(1'b1, 12);
    drop_run(1'b0, 6);
    for (int a = 0; a < 2; a++) begin
      alt_atm = a[0];
      repeat (20) begin
        @(negedge i_clock);
        check(dclk, alt_atm ? atm : hdlc);
        hdlc = 1'($random(seed));
        atm  = 1'($random(seed));
      end
    end
    loss_case(MODE_DS3, 180, 1'b1);
    thr = 16'h0010 + (16'($random(seed)) & 16'h000F);
    loss_case(MODE_STS1, int'(thr), 1'b1);
    loss_case(MODE_E3, 32, 1'b1);
    loss_case(MODE_DS3, 180, 1'b1);
    thr = 16'h0000;
    loss_case(MODE_STS1, 40, 1'b0);
    results();
  end
endmodule

`default_nettype wire
